// [hdl/kwt_axi_slave.sv]
`timescale 1ns/1ns
module kwt_axi_slave
   import kwt_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic [KWT_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic      [1:0]            s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [KWT_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic      [31:0]           s_axi_rdata,
   output logic      [1:0]            s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic                       wr_en,
   output logic      [KWT_ADDR_W-1:0] wr_addr,
   output logic      [31:0]           wr_data,
   output logic      [3:0]            wr_strb,
   input  wire logic                  wr_hit,
   input  wire logic [31:0]           rd_data,
   input  wire logic                  rd_hit
);

   typedef struct packed {
      logic                  aw_held;
      logic                  w_held;
      logic [KWT_ADDR_W-1:0] addr;
      logic [31:0]           data;
      logic [3:0]            strb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
   } kwt_bus_type;

   kwt_bus_type bus_reg;
   kwt_bus_type bus_next;

   assign s_axi_awready = !bus_reg.aw_held && !bus_reg.bvalid;
   assign s_axi_wready  = !bus_reg.w_held && !bus_reg.bvalid;
   assign s_axi_arready = !bus_reg.rvalid;
   assign s_axi_bvalid  = bus_reg.bvalid;
   assign s_axi_bresp   = bus_reg.bresp;
   assign s_axi_rvalid  = bus_reg.rvalid;
   assign s_axi_rdata   = bus_reg.rdata;
   assign s_axi_rresp   = bus_reg.rresp;
   // the write reaches the core in the cycle both halves are held
   assign wr_en         = bus_reg.aw_held && bus_reg.w_held;
   assign wr_addr       = bus_reg.addr;
   assign wr_data       = bus_reg.data;
   assign wr_strb       = bus_reg.strb;

   always_comb begin
      bus_next = bus_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         bus_next.aw_held = 1'b1;
         bus_next.addr    = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         bus_next.w_held = 1'b1;
         bus_next.data   = s_axi_wdata;
         bus_next.strb   = s_axi_wstrb;
      end
      if (wr_en) begin
         bus_next.aw_held = 1'b0;
         bus_next.w_held  = 1'b0;
         bus_next.bvalid  = 1'b1;
         bus_next.bresp   = wr_hit ? KWT_RESP_OKAY : KWT_RESP_SLVERR;
      end else if (bus_reg.bvalid && s_axi_bready) begin
         bus_next.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         bus_next.rvalid = 1'b1;
         bus_next.rdata  = rd_data;
         bus_next.rresp  = rd_hit ? KWT_RESP_OKAY : KWT_RESP_SLVERR;
      end else if (bus_reg.rvalid && s_axi_rready) begin
         bus_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_reg <= '0;
      end else begin
         bus_reg <= bus_next;
      end
   end

endmodule // kwt_axi_slave

// [hdl/kwt_pkg.sv]
package kwt_pkg;

   // register byte addresses on the bus
   localparam int          KWT_ADDR_W        = 8;
   localparam logic [7:0]  KWT_ADDR_PERIOD   = 8'h00;
   localparam logic [7:0]  KWT_ADDR_COUNT    = 8'h04;
   localparam logic [7:0]  KWT_ADDR_CTRL1    = 8'h08;
   localparam logic [7:0]  KWT_ADDR_CTRL2    = 8'h0C;
   localparam logic [7:0]  KWT_ADDR_PRESC    = 8'h10;

   // control_register_one fields
   localparam int          KWT_DIVIDE_LSB    = 0;
   localparam int          KWT_SELECT_LSB    = 4;
   localparam int          KWT_FREE_BIT      = 8;
   localparam int          KWT_SOFT_BIT      = 9;

   // control_register_two fields
   localparam int          KWT_KEY_LSB       = 0;
   localparam int          KWT_PMODE_BIT     = 12;
   localparam int          KWT_ENABLE_BIT    = 14;
   localparam int          KWT_FLAG_BIT      = 15;

   // reset values
   localparam logic [15:0] KWT_PERIOD_RESET  = 16'hFFFF;
   localparam logic [15:0] KWT_COUNT_RESET   = 16'hFFFF;
   localparam logic [15:0] KWT_PRESC_RESET   = 16'h0000;
   localparam logic [3:0]  KWT_DIVIDE_RESET  = 4'hF;
   localparam logic        KWT_PMODE_RESET   = 1'b1;

   // service keys
   localparam logic [11:0] KWT_KEY_ARM       = 12'h5C6;
   localparam logic [11:0] KWT_KEY_SERVICE   = 12'hA7E;

   // timeout event selection
   typedef enum logic [1:0] {
      KWT_SEL_INTERRUPT = 2'h0,
      KWT_SEL_RESET     = 2'h1,
      KWT_SEL_NMI       = 2'h2,
      KWT_SEL_NONE      = 2'h3
   } kwt_select_type;
   localparam logic [1:0]  KWT_SELECT_RESET  = 2'h3;

   // watchdog states, one-hot
   typedef enum logic [3:0] {
      KWT_ST_INIT    = 4'h1,
      KWT_ST_PRE     = 4'h2,
      KWT_ST_ACTIVE  = 4'h4,
      KWT_ST_TIMEOUT = 4'h8
   } kwt_state_type;

   // indirect prescaler presets, indexed by the divide field
   localparam logic [15:0] KWT_PRESET_TABLE [16] = '{
      16'h0001, 16'h0003, 16'h0007, 16'h000F, 16'h001F, 16'h003F, 16'h007F, 16'h00FF,
      16'h01FF, 16'h03FF, 16'h07FF, 16'h0FFF, 16'h1FFF, 16'h3FFF, 16'h7FFF, 16'hFFFF
   };

   // bus responses
   localparam logic [1:0]  KWT_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  KWT_RESP_SLVERR   = 2'h2;

endpackage

// [hdl/kwt_preset.sv]
`timescale 1ns/1ns
module kwt_preset
   import kwt_pkg::*;
(
   input  wire logic [3:0]  divide,
   input  wire logic        prescale_mode_bit,
   output logic      [15:0] load_value
);

   always_comb begin
      if (prescale_mode_bit) begin
         load_value = KWT_PRESET_TABLE[divide];
      end else begin
         load_value = {12'h000, divide};
      end
   end

endmodule // kwt_preset

// [hdl/kwt_watchdog.sv]
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module kwt_watchdog
   import kwt_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic [KWT_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic      [1:0]            s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [KWT_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic      [31:0]           s_axi_rdata,
   output logic      [1:0]            s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  clock_generator_domain_idle_status_bit,
   input  wire logic                  emulation_halt,
   output logic                       timeout_interrupt,
   output logic                       timeout_reset,
   output logic                       timeout_nmi
);

   typedef struct packed {
      kwt_state_type state;
      logic [15:0]   period_value;
      logic [15:0]   main_count;
      logic [15:0]   prescale_count;
      logic [3:0]    prescale_divide_field;
      logic [1:0]    timeout_event_select;
      logic          free_run;
      logic          soft_stop;
      logic          prescale_mode_bit;
      logic          armed;
      logic          timeout_flag;
      logic          event_interrupt;
      logic          event_reset;
      logic          event_nmi;
   } kwt_core_type;

   localparam kwt_core_type KWT_CORE_RESET = '{
      state:                 KWT_ST_INIT,
      period_value:          KWT_PERIOD_RESET,
      main_count:            KWT_COUNT_RESET,
      prescale_count:        KWT_PRESC_RESET,
      prescale_divide_field: KWT_DIVIDE_RESET,
      timeout_event_select:  KWT_SELECT_RESET,
      free_run:              1'b0,
      soft_stop:             1'b0,
      prescale_mode_bit:     KWT_PMODE_RESET,
      armed:                 1'b0,
      timeout_flag:          1'b0,
      event_interrupt:       1'b0,
      event_reset:           1'b0,
      event_nmi:             1'b0
   };

   kwt_core_type               core_reg;
   kwt_core_type               core_next;
   logic                       wr_en;
   logic      [KWT_ADDR_W-1:0] wr_addr;
   logic      [31:0]           wr_data;
   logic      [3:0]            wr_strb;
   logic                       wr_hit;
   logic      [31:0]           rd_data;
   logic                       rd_hit;
   logic      [15:0]           preset_load;
   logic                       load_mode;
   logic      [31:0]           merged;
   logic      [11:0]           key;
   logic                       clock_live;
   logic                       count_live;
   logic                       service;
   logic                       bad_key;

   // address decode shared by the read and the write path
   function automatic logic kwt_mapped(input logic [KWT_ADDR_W-1:0] addr);
      kwt_mapped = (addr == KWT_ADDR_PERIOD) || (addr == KWT_ADDR_COUNT) ||
                   (addr == KWT_ADDR_CTRL1) || (addr == KWT_ADDR_CTRL2) ||
                   (addr == KWT_ADDR_PRESC);
   endfunction

   // read image of each register, also the base for byte-lane merging
   function automatic logic [31:0] kwt_image(input kwt_core_type c, input logic [KWT_ADDR_W-1:0] addr);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (addr)
         KWT_ADDR_PERIOD: begin
            v[15:0] = c.period_value;
         end
         KWT_ADDR_COUNT: begin
            v[15:0] = c.main_count;
         end
         KWT_ADDR_CTRL1: begin
            v[KWT_DIVIDE_LSB +: 4] = c.prescale_divide_field;
            v[KWT_SELECT_LSB +: 2] = c.timeout_event_select;
            v[KWT_FREE_BIT]        = c.free_run;
            v[KWT_SOFT_BIT]        = c.soft_stop;
         end
         KWT_ADDR_CTRL2: begin
            // the key field always reads as zero
            v[KWT_PMODE_BIT]  = c.prescale_mode_bit;
            v[KWT_ENABLE_BIT] = (c.state == KWT_ST_ACTIVE);
            v[KWT_FLAG_BIT]   = c.timeout_flag;
         end
         KWT_ADDR_PRESC: begin
            v[15:0] = c.prescale_count;
         end
         default: begin
            v = 32'h0000_0000;
         end
      endcase
      kwt_image = v;
   endfunction

   kwt_axi_slave u_bus (
      .clk           (clk),
      .nrst          (nrst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_hit        (wr_hit),
      .rd_data       (rd_data),
      .rd_hit        (rd_hit)
   );

   kwt_preset u_preset (
      .divide            (core_reg.prescale_divide_field),
      .prescale_mode_bit (load_mode),
      .load_value        (preset_load)
   );

   assign rd_hit  = kwt_mapped(s_axi_araddr);
   assign rd_data = kwt_image(core_reg, s_axi_araddr);
   assign wr_hit  = kwt_mapped(wr_addr);

   // the enabling write may set the mode bit, so the first load follows the written value
   assign load_mode = (core_reg.state == KWT_ST_PRE && wr_en && wr_addr == KWT_ADDR_CTRL2) ?
                      merged[KWT_PMODE_BIT] : core_reg.prescale_mode_bit;

   assign timeout_interrupt = core_reg.event_interrupt;
   assign timeout_reset     = core_reg.event_reset;
   assign timeout_nmi       = core_reg.event_nmi;

   // byte lanes not strobed keep the current image
   always_comb begin
      merged = kwt_image(core_reg, wr_addr);
      for (int b = 0; b < 4; b++) begin
         if (wr_strb[b]) begin
            merged[8*b +: 8] = wr_data[8*b +: 8];
         end
      end
      // an unstrobed key lane reads as zero, which is a wrong key
      key = {wr_strb[1] ? wr_data[11:8] : 4'h0, wr_strb[0] ? wr_data[7:0] : 8'h00};
   end

   // the clock generator idle stands in for the stopped watchdog clock
   assign clock_live = !clock_generator_domain_idle_status_bit &&
                       (!emulation_halt || core_reg.free_run);
   assign count_live = !clock_generator_domain_idle_status_bit &&
                       (!emulation_halt || core_reg.free_run ||
                        (core_reg.soft_stop && core_reg.main_count != 16'h0000));

   assign service = wr_en && (wr_addr == KWT_ADDR_CTRL2) && core_reg.armed &&
                    (key == KWT_KEY_SERVICE);
   assign bad_key = wr_en && (wr_addr == KWT_ADDR_CTRL2) &&
                    (key != KWT_KEY_ARM) && !service;

   always_comb begin
      core_next                 = core_reg;
      core_next.event_interrupt = 1'b0;
      core_next.event_reset     = 1'b0;
      core_next.event_nmi       = 1'b0;
      case (core_reg.state)
         KWT_ST_INIT: begin
            // configuration is free; counters stay idle until enabled
            if (wr_en) begin
               case (wr_addr)
                  KWT_ADDR_PERIOD: begin
                     core_next.period_value = merged[15:0];
                  end
                  KWT_ADDR_COUNT: begin
                     core_next.main_count = merged[15:0];
                  end
                  KWT_ADDR_CTRL1: begin
                     core_next.prescale_divide_field = merged[KWT_DIVIDE_LSB +: 4];
                     core_next.timeout_event_select  = merged[KWT_SELECT_LSB +: 2];
                     core_next.free_run              = merged[KWT_FREE_BIT];
                     core_next.soft_stop             = merged[KWT_SOFT_BIT];
                  end
                  KWT_ADDR_CTRL2: begin
                     core_next.prescale_mode_bit = merged[KWT_PMODE_BIT];
                     if (key == KWT_KEY_ARM) begin
                        core_next.state = KWT_ST_PRE;
                        core_next.armed = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         KWT_ST_PRE: begin
            if (wr_en) begin
               case (wr_addr)
                  KWT_ADDR_PERIOD: begin
                     core_next.period_value = merged[15:0];
                  end
                  KWT_ADDR_COUNT: begin
                     core_next.main_count = merged[15:0];
                  end
                  KWT_ADDR_CTRL1: begin
                     core_next.prescale_divide_field = merged[KWT_DIVIDE_LSB +: 4];
                     core_next.timeout_event_select  = merged[KWT_SELECT_LSB +: 2];
                     core_next.free_run              = merged[KWT_FREE_BIT];
                     core_next.soft_stop             = merged[KWT_SOFT_BIT];
                  end
                  KWT_ADDR_CTRL2: begin
                     // a write without a correct key is dropped here
                     if (key == KWT_KEY_ARM) begin
                        core_next.prescale_mode_bit = merged[KWT_PMODE_BIT];
                        core_next.armed             = 1'b1;
                     end else if (key == KWT_KEY_SERVICE) begin
                        core_next.prescale_mode_bit = merged[KWT_PMODE_BIT];
                        core_next.armed             = 1'b0;
                        if (merged[KWT_ENABLE_BIT]) begin
                           core_next.state          = KWT_ST_ACTIVE;
                           core_next.main_count     = core_reg.period_value;
                           core_next.prescale_count = preset_load;
                        end else begin
                           core_next.state = KWT_ST_INIT;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         KWT_ST_ACTIVE: begin
            // settings are frozen and the enable bit cannot be cleared
            if (clock_live && core_reg.main_count == 16'h0000) begin
               core_next.state = KWT_ST_TIMEOUT;
            end else if (bad_key) begin
               core_next.state = KWT_ST_TIMEOUT;
            end else if (service) begin
               core_next.armed          = 1'b0;
               core_next.main_count     = core_reg.period_value;
               core_next.prescale_count = preset_load;
            end else begin
               if (wr_en && wr_addr == KWT_ADDR_CTRL2) begin
                  core_next.armed = 1'b1;
               end
               if (count_live) begin
                  if (core_reg.prescale_count == 16'h0000) begin
                     core_next.prescale_count = preset_load;
                     core_next.main_count     = core_reg.main_count - 16'h0001;
                  end else begin
                     core_next.prescale_count = core_reg.prescale_count - 16'h0001;
                  end
               end
            end
            if (core_next.state == KWT_ST_TIMEOUT) begin
               core_next.timeout_flag = 1'b1;
               core_next.armed        = 1'b0;
               case (core_reg.timeout_event_select)
                  KWT_SEL_INTERRUPT: begin
                     core_next.event_interrupt = 1'b1;
                  end
                  KWT_SEL_RESET: begin
                     core_next.event_reset = 1'b1;
                  end
                  KWT_SEL_NMI: begin
                     core_next.event_nmi = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         KWT_ST_TIMEOUT: begin
            // dead until reset: counters hold and the event stays cut off
            core_next.state = KWT_ST_TIMEOUT;
         end
         default: begin
            core_next = KWT_CORE_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_reg <= KWT_CORE_RESET;
      end else begin
         core_reg <= core_next;
      end
   end

endmodule // kwt_watchdog

// [verification/kwt_event_sink.sv]
`timescale 1ns/1ns
// cpu side: latches events; does not reset the block itself
module kwt_event_sink (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       timeout_interrupt,
   input  wire logic       timeout_reset,
   input  wire logic       timeout_nmi,
   output logic      [2:0] event_seen
);
   always_ff @(posedge clk or negedge nrst)
      if (!nrst) event_seen <= 3'h0;
      else event_seen <= event_seen | {timeout_nmi, timeout_reset, timeout_interrupt};
endmodule // kwt_event_sink

// [verification/kwt_monitor.sv]
`timescale 1ns/1ns
module kwt_monitor (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        clock_generator_domain_idle_status_bit,
   input wire logic        timeout_interrupt,
   input wire logic        timeout_reset,
   input wire logic        timeout_nmi
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic ev, fired_reg;
   assign ev = timeout_interrupt | timeout_reset | timeout_nmi;
   // a second event would hit a cpu that is already recovering
   always_ff @(posedge clk or negedge nrst)
      if (!nrst) fired_reg <= 1'h0;
      else if (ev) fired_reg <= 1'h1;
   sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
   chk_event_onehot: assert property ($onehot0({timeout_interrupt, timeout_reset, timeout_nmi}))
      else $error("two events at once");
   chk_event_once: assert property (!(ev && fired_reg))
      else $error("event after timeout");
   chk_idle_quiet: assert property ($past(clock_generator_domain_idle_status_bit) && !s_axi_bvalid |-> !ev)
      else $error("event while idle");
   // the write lands one edge after both halves are taken, and the response is raised at that same edge
   chk_write_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
      else $error("no write response");
   chk_read_answer: assert property (s_rd |=> s_axi_rvalid)
      else $error("no read response");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken in response");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken in response");
endmodule // kwt_monitor

bind kwt_watchdog kwt_monitor i_mon (.*);

// [verification/tb.sv]
`timescale 1ns/1ns
module tb
   import kwt_pkg::*;
;
   logic        clk = 1'h0, nrst = 1'h0, clock_generator_domain_idle_status_bit = 1'h0, emulation_halt = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr, rb;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        timeout_interrupt, timeout_reset, timeout_nmi;
   logic [2:0]  event_seen;
   int          fails = 0, checks_done = 0, cycles = 0;
   kwt_watchdog   i_dut (.*);
   kwt_event_sink i_sink (.*);
   always #25 clk = ~clk;
   task automatic summarize();
      if (fails == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles > 8000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic rst();
      nrst <= 1'h0;
      repeat (12) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit pa = 1, pw = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (pa || pw) begin
         @(posedge clk);
         if (pa && s_axi_awready) begin
            pa = 0;
            s_axi_awvalid <= 1'h0;
         end
         if (pw && s_axi_wready) begin
            pw = 0;
            s_axi_wvalid <= 1'h0;
         end
      end
      s_axi_bready <= 1'h1;
      do @(posedge clk); while (s_axi_bvalid !== 1'h1);
      rb = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (s_axi_rvalid !== 1'h1);
      // late rready keeps the response waiting one cycle
      s_axi_rready <= 1'h1;
      @(posedge clk);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic rc(input logic [7:0] a, input string n, input logic [31:0] e);
      rd(a);
      chk(n, rv, e);
   endtask
   task automatic arm(input logic [31:0] p, input logic [31:0] c1, input logic [31:0] c2);
      rst();
      wr(KWT_ADDR_PERIOD, p);
      wr(KWT_ADDR_CTRL1, c1);
      wr(KWT_ADDR_CTRL2, 32'h05C6);
      wr(KWT_ADDR_CTRL2, c2);
   endtask
   task automatic reset_values();
      repeat (20) @(posedge clk);
      rc(KWT_ADDR_PERIOD, "period rst", 32'hFFFF);
      rc(KWT_ADDR_COUNT, "count", 32'hFFFF);
      rc(KWT_ADDR_PRESC, "presc", 32'h0);
      rc(KWT_ADDR_CTRL1, "ctrl1", 32'h003F);
      rc(KWT_ADDR_CTRL2, "ctrl2", 32'h1000);
      wr(KWT_ADDR_PERIOD, 32'h1234);
      chk("wr okay", rb, KWT_RESP_OKAY);
      rc(KWT_ADDR_PERIOD, "period", 32'h1234);
      wr(8'h14, 32'h0);
      chk("wr unmapped", rb, KWT_RESP_SLVERR);
      rd(8'h14);
      chk("unmapped", rr, KWT_RESP_SLVERR);
   endtask
   task automatic wrong_key();
      for (int s = 0; s < 4; s++) begin
         arm(32'hFFFF, 32'h000F | (s << 4), 32'h4A7E);
         rc(KWT_ADDR_CTRL2, "enabled", 32'h4000);
         chk("read quiet", event_seen, 3'h0);
         wr(KWT_ADDR_CTRL2, 32'h0123);
         @(posedge clk);
         chk("event", event_seen, (s == 3) ? 3'h0 : 3'h1 << s);
         rc(KWT_ADDR_CTRL2, "flag", 32'h8000);
      end
   endtask
   task automatic loads();
      clock_generator_domain_idle_status_bit <= 1'h1;
      arm(32'h0033, 32'h0002, 32'h5A7E);
      repeat (20) @(posedge clk);
      rc(KWT_ADDR_COUNT, "idle count", 32'h0033);
      rc(KWT_ADDR_PRESC, "indirect", 32'h0007);
      arm(32'h0033, 32'h0005, 32'h4A7E);
      rc(KWT_ADDR_PRESC, "direct", 32'h0005);
      emulation_halt <= 1'h1;
      clock_generator_domain_idle_status_bit <= 1'h0;
      repeat (20) @(posedge clk);
      rc(KWT_ADDR_COUNT, "hard stop", 32'h0033);
      // soft stop: counts down to zero under halt, times out once the halt ends
      arm(32'h0002, 32'h0200, 32'h4A7E);
      repeat (20) @(posedge clk);
      rc(KWT_ADDR_COUNT, "soft stop", 32'h0);
      chk("soft quiet", event_seen, 3'h0);
      emulation_halt <= 1'h0;
      repeat (3) @(posedge clk);
      chk("soft resume", event_seen, 3'h1);
   endtask
   task automatic service();
      arm(32'h0014, 32'h0001, 32'h4A7E);
      // ten services outlast one unserviced period, so a missing reload shows up
      repeat (10) begin
         wr(KWT_ADDR_CTRL2, 32'h05C6);
         wr(KWT_ADDR_CTRL2, 32'h0A7E);
      end
      chk("serviced", event_seen, 3'h0);
      rc(KWT_ADDR_CTRL2, "no disable", 32'h4000);
   endtask
   task automatic expire(input logic [15:0] p, input logic [3:0] d);
      int n = 0;
      arm({16'h0, p}, {28'h0, d}, 32'h4A7E);
      while (timeout_interrupt !== 1'h1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("expiry", n, p * (d + 1) + 1);
      wr(KWT_ADDR_CTRL2, 32'h05C6);
      rc(KWT_ADDR_CTRL2, "stays off", 32'h8000);
   endtask
   initial begin
      rst();
      reset_values();
      wrong_key();
      loads();
      service();
      expire(16'h0002, 4'h0);
      expire(16'h0003, 4'h1);
      summarize();
   end
endmodule // tb
